//--- logic/agic_pkg.sv
/*
 * constants for the converter gain and interleave control block:
 * register indices, field positions, reset values and tracker counts.
 * assumes a 16-bit register word and a 5-bit register index on the host port.
 */
package agic_pkg;

    localparam int          ADDR_W        = 5;
    localparam int          DATA_W        = 16;
    localparam int          GAIN_W        = 9;
    localparam int          COARSE_W      = 3;
    localparam int          FINE_W        = 9;
    localparam int          DELAY_W       = COARSE_W + FINE_W;

    // register indices
    localparam logic [4:0]  GAIN_IDX      = 5'h0b;
    localparam logic [4:0]  ILV_IDX       = 5'h0d;
    localparam logic [4:0]  STATUS_IDX    = 5'h10;

    // field positions
    localparam int          GAIN_MSB      = 15;
    localparam int          GAIN_LSB      = 7;
    localparam int          ILV_EN_BIT    = 15;
    localparam int          AUTO_PH_BIT   = 14;

    // values after reset, and the trim maximum
    localparam logic [15:0] GAIN_REG_RST  = 16'h807f;
    localparam logic [15:0] ILV_REG_RST   = 16'h3fff;
    localparam logic [8:0]  GAIN_RST      = GAIN_REG_RST[15:7];
    localparam logic [11:0] TRIM_RST      = 12'h800;
    localparam logic [11:0] TRIM_MAX      = 12'hfff;

    // full-scale range in millivolts, peak to peak
    localparam logic [9:0]  FS_MIN_MV     = 10'h230;
    localparam logic [8:0]  FS_SLOPE      = 9'h119;
    localparam int          FS_SHIFT      = 9;

    // quiet cycles of the phase detector before the tracker reports lock
    localparam int          LOCK_QUIET_CYC = 16;
    localparam logic [4:0]  LOCK_QUIET_CNT = 5'(LOCK_QUIET_CYC);

    typedef enum logic [1:0] {
        AGIC_PT_IDLE   = 2'b00,
        AGIC_PT_TRACK  = 2'b01,
        AGIC_PT_LOCKED = 2'b11
    } agic_track_t;

endpackage : agic_pkg

//--- logic/agic_sync3.sv
/*
 * three-stage synchroniser with agreement filter for one pin level.
 * assumes the input is asynchronous to CLOCK_I; output changes only when
 * the second and third stages agree.
 */
`timescale 1ns/10ps
module agic_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic pin_i,
    output logic      level_o
);
    logic meta;
    logic s2;
    logic s3;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta <= RST_VAL;
            s2   <= RST_VAL;
            s3   <= RST_VAL;
        end else begin
            meta <= pin_i;
            s2   <= meta;
            s3   <= s2;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            level_o <= RST_VAL;
        end else if (s2 == s3) begin
            level_o <= s3;
        end
    end

endmodule : agic_sync3

//--- logic/agic_top.sv
/*
 * gain and interleave control of a dual converter: the second channel's
 * full-scale code, dual edge sampling enable and clock phase alignment.
 * assumes a host on the same clock using the strobed register port; phase
 * detector flags and manual delay values arrive from outside.
 */
// Our own choice: the strobed register port.
`timescale 1ns/10ps
module agic_top (
    input  wire logic                           CLOCK_I,
    input  wire logic                           NRST_I,
    input  wire logic [agic_pkg::ADDR_W-1:0]    ADDR_I,
    input  wire logic [agic_pkg::DATA_W-1:0]    WDATA_I,
    input  wire logic                           WR_I,
    input  wire logic                           RD_I,
    output logic      [agic_pkg::DATA_W-1:0]    RDATA_O,
    input  wire logic [agic_pkg::COARSE_W-1:0]  MAN_COARSE_I,
    input  wire logic [agic_pkg::FINE_W-1:0]    MAN_FINE_I,
    input  wire logic                           PHASE_LEAD_I,
    input  wire logic                           PHASE_LAG_I,
    output logic      [agic_pkg::GAIN_W-1:0]    GAIN_CODE_O,
    output logic      [9:0]                     FS_MV_O,
    output logic                                INTERLEAVE_ENABLE_O,
    output logic                                AUTO_PHASE_ALIGN_O,
    output logic                                SHARED_INPUT_O,
    output logic                                CONV_A_O,
    output logic                                CONV_B_O,
    output logic      [agic_pkg::DELAY_W-1:0]   CLK_DELAY_O,
    output logic                                PHASE_LOCKED_O
);
    import agic_pkg::*;

    logic [GAIN_W-1:0]  gain_code;
    logic               interleave_enable;
    logic               auto_phase_align;
    logic [DELAY_W-1:0] trim;
    logic [4:0]         quiet_cnt;
    logic               conv_turn;
    logic               lead_q;
    logic               lag_q;
    logic               first_cyc;
    agic_track_t        track_state;
    agic_track_t        next_track_state;
    logic               wr_gain;
    logic               wr_ilv;
    logic [9:0]         next_fs_mv;
    logic [17:0]        fs_prod;

    assign wr_gain = WR_I && (ADDR_I == GAIN_IDX);
    assign wr_ilv  = WR_I && (ADDR_I == ILV_IDX);

    // phase detector flags come from pins
    agic_sync3 #(.RST_VAL(1'b0)) u_lead_sync (
        .clk_i   (CLOCK_I),
        .nrst_i  (NRST_I),
        .pin_i   (PHASE_LEAD_I),
        .level_o (lead_q)
    );

    agic_sync3 #(.RST_VAL(1'b0)) u_lag_sync (
        .clk_i   (CLOCK_I),
        .nrst_i  (NRST_I),
        .pin_i   (PHASE_LAG_I),
        .level_o (lag_q)
    );

    // gain word; low bits are fillers and not stored
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            gain_code <= GAIN_RST;
        end else if (wr_gain) begin
            gain_code <= WDATA_I[GAIN_MSB:GAIN_LSB];
        end
    end

    // interleave word
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            interleave_enable <= ILV_REG_RST[ILV_EN_BIT];
            auto_phase_align  <= ILV_REG_RST[AUTO_PH_BIT];
        end else if (wr_ilv) begin
            interleave_enable <= WDATA_I[ILV_EN_BIT];
            auto_phase_align  <= WDATA_I[AUTO_PH_BIT];
        end
    end

    // linear, monotonic full-scale range from the gain code
    always_comb begin
        fs_prod    = 18'(gain_code) * 18'(FS_SLOPE);
        next_fs_mv = FS_MIN_MV + 10'(fs_prod >> FS_SHIFT);
    end

    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            FS_MV_O <= FS_MIN_MV;
        end else begin
            FS_MV_O <= next_fs_mv;
        end
    end

    assign GAIN_CODE_O         = gain_code;
    assign INTERLEAVE_ENABLE_O = interleave_enable;
    assign AUTO_PHASE_ALIGN_O  = auto_phase_align;

    // conversion sequencing
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            conv_turn <= 1'b0;
        end else if (interleave_enable) begin
            conv_turn <= !conv_turn;
        end else begin
            conv_turn <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            SHARED_INPUT_O <= 1'b0;
            CONV_A_O       <= 1'b0;
            CONV_B_O       <= 1'b0;
        end else if (interleave_enable) begin
            SHARED_INPUT_O <= 1'b1;
            CONV_A_O       <= !conv_turn;
            CONV_B_O       <= conv_turn;
        end else begin
            SHARED_INPUT_O <= 1'b0;
            CONV_A_O       <= 1'b1;
            CONV_B_O       <= 1'b1;
        end
    end

    // phase tracker: moves the trim toward half a period between edges
    always_comb begin
        next_track_state = track_state;
        case (track_state)
            AGIC_PT_IDLE: begin
                if (auto_phase_align) begin
                    next_track_state = AGIC_PT_TRACK;
                end
            end
            AGIC_PT_TRACK: begin
                if (!auto_phase_align) begin
                    next_track_state = AGIC_PT_IDLE;
                end else if (quiet_cnt == LOCK_QUIET_CNT) begin
                    next_track_state = AGIC_PT_LOCKED;
                end
            end
            AGIC_PT_LOCKED: begin
                if (!auto_phase_align) begin
                    next_track_state = AGIC_PT_IDLE;
                end else if (lead_q || lag_q) begin
                    next_track_state = AGIC_PT_TRACK;
                end
            end
            default: begin
                next_track_state = AGIC_PT_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            track_state <= AGIC_PT_IDLE;
        end else begin
            track_state <= next_track_state;
        end
    end

    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            quiet_cnt <= '0;
        end else if (track_state != AGIC_PT_TRACK || lead_q || lag_q) begin
            quiet_cnt <= '0;
        end else if (quiet_cnt != LOCK_QUIET_CNT) begin
            quiet_cnt <= quiet_cnt + 5'h01;
        end
    end

    // lead shortens the delay, lag lengthens it; saturates at the ends
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            trim <= TRIM_RST;
        end else if (auto_phase_align) begin
            if (lead_q && !lag_q && trim != '0) begin
                trim <= trim - 12'h001;
            end else if (lag_q && !lead_q && trim != TRIM_MAX) begin
                trim <= trim + 12'h001;
            end
        end
    end

    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            CLK_DELAY_O <= '0;
        end else if (auto_phase_align) begin
            CLK_DELAY_O <= trim;
        end else begin
            CLK_DELAY_O <= {MAN_COARSE_I, MAN_FINE_I};
        end
    end

    assign PHASE_LOCKED_O = (track_state == AGIC_PT_LOCKED);

    // read port: control words never read back, status does
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            RDATA_O <= '0;
        end else if (RD_I && ADDR_I == STATUS_IDX) begin
            RDATA_O <= {12'h000, PHASE_LOCKED_O, track_state == AGIC_PT_TRACK,
                        auto_phase_align, interleave_enable};
        end else begin
            RDATA_O <= '0;
        end
    end

    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            first_cyc <= 1'b1;
        end else begin
            first_cyc <= 1'b0;
        end
    end

    default clocking agic_cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!NRST_I);

    gain_reset_a: assert property (first_cyc |-> gain_code == GAIN_RST)
        else $error("gain code not midscale after reset");

    gain_apply_a: assert property (wr_gain |=> GAIN_CODE_O == $past(WDATA_I[15:7]))
        else $error("gain code not applied one cycle after write");

    fs_track_a: assert property (
        gain_code == GAIN_RST |=> FS_MV_O == 10'h2bc)
        else $error("midscale gain does not give nominal range");

    fs_mono_a: assert property (
        (gain_code > $past(gain_code)) |=> FS_MV_O >= $past(FS_MV_O))
        else $error("full-scale range not monotonic in gain code");

    ilv_enter_a: assert property (
        wr_ilv && WDATA_I[ILV_EN_BIT] |=> INTERLEAVE_ENABLE_O ##1 SHARED_INPUT_O)
        else $error("dual edge sampling not entered after write");

    conv_alt_a: assert property (
        interleave_enable [*3] |-> CONV_A_O != CONV_B_O && CONV_A_O != $past(CONV_A_O))
        else $error("converters do not alternate in dual edge sampling");

    indep_conv_a: assert property (
        !interleave_enable ##1 !interleave_enable |-> !SHARED_INPUT_O && CONV_A_O && CONV_B_O)
        else $error("channels not independent with interleave off");

    auto_ignore_a: assert property (
        auto_phase_align |=> CLK_DELAY_O == $past(trim))
        else $error("manual delay used while auto alignment on");

    track_lead_a: assert property (
        auto_phase_align && lead_q && !lag_q && trim != '0 |=> trim == $past(trim) - 12'h001)
        else $error("tracker did not pull delay in on lead");

    manual_delay_a: assert property (
        !auto_phase_align |=> CLK_DELAY_O == {$past(MAN_COARSE_I), $past(MAN_FINE_I)})
        else $error("manual delay not applied with auto alignment off");

    no_readback_a: assert property (
        RD_I && (ADDR_I == GAIN_IDX || ADDR_I == ILV_IDX) |=> RDATA_O == '0)
        else $error("control word read back");

    track_lag_a: assert property (
        auto_phase_align && lag_q && !lead_q && trim != TRIM_MAX
        |=> trim == $past(trim) + 12'h001)
        else $error("tracker did not push delay out on lag");

    trim_hold_a: assert property (
        !auto_phase_align || (lead_q == lag_q) |=> $stable(trim))
        else $error("trim moved without a single phase flag");

    lock_entry_a: assert property (
        track_state == AGIC_PT_TRACK && auto_phase_align && quiet_cnt == LOCK_QUIET_CNT
        |=> PHASE_LOCKED_O)
        else $error("tracker did not lock after the quiet count");

    lock_drop_a: assert property (
        PHASE_LOCKED_O && (lead_q || lag_q || !auto_phase_align) |=> !PHASE_LOCKED_O)
        else $error("tracker stayed locked with a phase error");

    align_off_a: assert property (
        !auto_phase_align |=> track_state == AGIC_PT_IDLE)
        else $error("tracker running with auto alignment off");

    auto_enter_a: assert property (
        wr_ilv && WDATA_I[AUTO_PH_BIT] |=> AUTO_PHASE_ALIGN_O ##1 CLK_DELAY_O == $past(trim))
        else $error("auto alignment not taken after write");

    rdata_idle_a: assert property (
        !RD_I |=> RDATA_O == '0)
        else $error("read data present without a read");

    status_read_a: assert property (
        RD_I && ADDR_I == STATUS_IDX
        |=> RDATA_O[1:0] == $past({auto_phase_align, interleave_enable}))
        else $error("status read does not show the mode bits");

    fs_min_a: assert property (
        gain_code == '0 |=> FS_MV_O == FS_MIN_MV)
        else $error("zero gain code does not give minimum range");

    fs_max_a: assert property (
        gain_code == '1 |=> FS_MV_O == 10'h348)
        else $error("full gain code does not give maximum range");

    ilv_leave_a: assert property (
        wr_ilv && !WDATA_I[ILV_EN_BIT] |=> !INTERLEAVE_ENABLE_O ##1 !SHARED_INPUT_O)
        else $error("dual edge sampling not left after write");

    conv_excl_a: assert property (
        interleave_enable ##1 interleave_enable |-> SHARED_INPUT_O && CONV_A_O != CONV_B_O)
        else $error("both converters strobed together in dual edge sampling");

    gain_hold_a: assert property (
        !wr_gain |=> $stable(GAIN_CODE_O))
        else $error("gain code changed without a write");

    mode_hold_a: assert property (
        !wr_ilv |=> $stable(INTERLEAVE_ENABLE_O) && $stable(AUTO_PHASE_ALIGN_O))
        else $error("mode bits changed without a write");

    cov_interleave_c: cover property (wr_ilv && WDATA_I[ILV_EN_BIT] ##3 CONV_B_O && !CONV_A_O);
    cov_lock_c:       cover property (auto_phase_align ##[1:40] PHASE_LOCKED_O);
    cov_gain_c:       cover property (wr_gain ##1 GAIN_CODE_O == '1);
    cov_manual_c:     cover property (!auto_phase_align && wr_ilv && WDATA_I[AUTO_PH_BIT]);
    cov_unlock_c:     cover property (PHASE_LOCKED_O ##1 !PHASE_LOCKED_O && auto_phase_align);

endmodule : agic_top

//--- tb/agic_testbench.sv
/*
 * self-checking bench for the gain and interleave control block.
 * assumes the design drives its register outputs one edge after a write,
 * and that the phase pins pass a synchroniser of equal rise and fall delay.
 */
`timescale 1ns/10ps
module testbench;
    import agic_pkg::*;

    typedef struct {int sel; logic [15:0] exp;} agic_note_t;

    logic                 clk;
    logic                 nrst;
    logic [ADDR_W-1:0]    addr;
    logic [DATA_W-1:0]    wdata;
    logic                 wr;
    logic                 rd;
    logic [COARSE_W-1:0]  coarse;
    logic [FINE_W-1:0]    fine;
    logic                 lead;
    logic                 lag;
    wire  [DATA_W-1:0]    rdata;
    wire  [GAIN_W-1:0]    gain;
    wire  [9:0]           fs_mv;
    wire                  ilv;
    wire                  auto_ph;
    wire                  shared;
    wire                  conv_a;
    wire                  conv_b;
    wire  [DELAY_W-1:0]   delay;
    wire                  locked;
    int                   fails;
    int                   checks;
    int                   seed;
    int                   code;
    agic_note_t           notes[$];
    event                 sample_ev;

    agic_top dut (.CLOCK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .MAN_COARSE_I(coarse), .MAN_FINE_I(fine),
        .PHASE_LEAD_I(lead), .PHASE_LAG_I(lag), .GAIN_CODE_O(gain), .FS_MV_O(fs_mv),
        .INTERLEAVE_ENABLE_O(ilv), .AUTO_PHASE_ALIGN_O(auto_ph), .SHARED_INPUT_O(shared),
        .CONV_A_O(conv_a), .CONV_B_O(conv_b), .CLK_DELAY_O(delay), .PHASE_LOCKED_O(locked));

    initial clk = 1'b0;
    always #50 clk = ~clk;

    function automatic logic [15:0] pick(input int sel);
        case (sel)
            0: pick = {7'h00, gain};
            1: pick = {6'h00, fs_mv};
            2: pick = {15'h0000, ilv};
            3: pick = {15'h0000, auto_ph};
            4: pick = {15'h0000, shared};
            5: pick = {14'h0000, conv_a, conv_b};
            6: pick = {4'h0, delay};
            8: pick = {15'h0000, locked};
            default: pick = rdata;
        endcase
    endfunction : pick

    // queue a note; the watcher compares it against the output at once
    task automatic chk(input int sel, input logic [15:0] exp);
        notes.push_back('{sel, exp});
        -> sample_ev;
    endtask : chk

    always begin
        @(sample_ev);
        while (notes.size() > 0) begin
            agic_note_t n;
            n = notes.pop_front();
            checks++;
            if (pick(n.sel) !== n.exp) begin
                fails++;
                $display("[FAIL] t=%0t sel %0d got %h exp %h", $time, n.sel, pick(n.sel), n.exp);
            end
        end
    end

    function automatic logic [15:0] fs_of(input int c);
        fs_of = 16'(560 + ((c * 281) >> 9));
    endfunction : fs_of

    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        chk(7, exp);
    endtask : rd_chk

    task automatic do_reset();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk(0, 16'h0100);
        chk(1, 16'h0230);
        chk(2, 16'h0000);
        @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk(1, fs_of(int'(GAIN_RST)));
    endtask : do_reset

    task automatic finish_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #500000;
        fails++;
        finish_test();
    end

    initial begin
        int codes[4];
        seed = 32'h5b9f;
        nrst = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        coarse = '0;
        fine = '0;
        lead = 1'b0;
        lag = 1'b0;
        do_reset();
        $display("reset test done");
        codes = '{0, 256, 511, 0};
        codes[3] = 32'h0c0 + ($random(seed) & 32'h0ff);
        foreach (codes[i]) begin
            wr_reg(GAIN_IDX, {9'(codes[i]), 7'h7f});
            @(negedge clk);
            chk(0, 16'(codes[i]));
            @(negedge clk);
            chk(1, fs_of(codes[i]));
        end
        wr_reg(5'h05, 16'h007f);
        rd_chk(GAIN_IDX, 16'h0000);
        rd_chk(ILV_IDX, 16'h0000);
        rd_chk(5'h1f, 16'h0000);
        chk(0, 16'(codes[3]));
        $display("gain test done");
        wr_reg(ILV_IDX, 16'hbfff);
        @(negedge clk);
        chk(2, 16'h0001);
        @(negedge clk);
        chk(4, 16'h0001);
        chk(5, 16'h0002);
        @(negedge clk);
        chk(5, 16'h0001);
        @(negedge clk);
        chk(5, 16'h0002);
        wr_reg(ILV_IDX, 16'h3fff);
        repeat (2) @(negedge clk);
        chk(2, 16'h0000);
        chk(4, 16'h0000);
        chk(5, 16'h0003);
        $display("interleave test done");
        @(posedge clk);
        coarse <= 3'($random(seed));
        fine   <= 9'($random(seed));
        repeat (2) @(negedge clk);
        chk(6, {4'h0, coarse, fine});
        wr_reg(ILV_IDX, 16'hffff);
        @(posedge clk);
        coarse <= ~coarse;
        fine   <= ~fine;
        repeat (3) @(negedge clk);
        chk(3, 16'h0001);
        chk(6, {4'h0, TRIM_RST});
        @(posedge clk);
        lag <= 1'b1;
        repeat (10) @(posedge clk);
        lag <= 1'b0;
        repeat (10) @(negedge clk);
        chk(6, {4'h0, TRIM_RST} + 16'h000a);
        @(posedge clk);
        lead <= 1'b1;
        repeat (4) @(posedge clk);
        lead <= 1'b0;
        repeat (10) @(negedge clk);
        chk(6, {4'h0, TRIM_RST} + 16'h0006);
        chk(8, 16'h0000);
        @(posedge clk);
        lead <= 1'b1;
        lag  <= 1'b1;
        repeat (8) @(negedge clk);
        chk(6, {4'h0, TRIM_RST} + 16'h0006);
        @(posedge clk);
        lead <= 1'b0;
        lag  <= 1'b0;
        repeat (30) @(negedge clk);
        chk(8, 16'h0001);
        rd_chk(STATUS_IDX, 16'h000b);
        @(posedge clk);
        lag <= 1'b1;
        repeat (6) @(negedge clk);
        chk(8, 16'h0000);
        @(posedge clk);
        lag <= 1'b0;
        $display("phase test done");
        do_reset();
        chk(0, 16'h0100);
        chk(3, 16'h0000);
        $display("second reset test done");
        @(negedge clk);
        finish_test();
    end
endmodule : testbench
